// file: core/ppsm_pkg.sv
// Constants, state codes and stream layout for the PoE port sequencer
package ppsm_pkg;

	// =====================================================================
	// System clock and port timers
	// =====================================================================
	localparam int unsigned SYS_CLK_HZ   = 20_000_000;
	localparam int unsigned CYC_PER_MS   = SYS_CLK_HZ / 1000;
	localparam int unsigned CYC_PER_US   = SYS_CLK_HZ / 1_000_000;
	localparam int unsigned STARTUP_MS   = 65;   // Inrush phase length
	localparam int unsigned UDL_MS       = 322;  // Under-load qualify time
	localparam int unsigned OVERLOAD_MS  = 75;   // Over-load timer
	localparam int unsigned PEAK_LIM_MS  = 60;   // Peak limit timer
	localparam int unsigned RECOVERY_MS  = 1000; // Retry after shutdown
	localparam int unsigned BACKOFF_US   = 100;  // Pause after failed search
	localparam int unsigned STARTUP_CYC  = STARTUP_MS * CYC_PER_MS;
	localparam int unsigned UDL_CYC      = UDL_MS * CYC_PER_MS;
	localparam int unsigned OVERLOAD_CYC = OVERLOAD_MS * CYC_PER_MS;
	localparam int unsigned PEAK_LIM_CYC = PEAK_LIM_MS * CYC_PER_MS;
	localparam int unsigned RECOVERY_CYC = RECOVERY_MS * CYC_PER_MS;
	localparam int unsigned BACKOFF_CYC  = BACKOFF_US * CYC_PER_US;
	localparam int unsigned TMR_W        = 25;   // Holds the one second count

	// =====================================================================
	// Monitoring stream timing on the link clock
	// =====================================================================
	localparam int unsigned LINK_PERIOD_NS = 160;
	localparam int unsigned BIT_NS         = 1000;
	localparam int unsigned GAP_NS         = 1000;
	// Half bit rounds down, so the bit never runs slower than 1 MHz
	localparam int unsigned HALF_CYC = BIT_NS / 2 / LINK_PERIOD_NS;
	// Gap is a least time, so it rounds up
	localparam int unsigned GAP_CYC  =
		(GAP_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;

	// =====================================================================
	// Packet layout, most significant bit sent first
	// =====================================================================
	localparam int unsigned PKT_BITS  = 116;
	localparam int unsigned TEST_BITS = 78;  // Five internal test fields
	localparam int unsigned PORT_VOLTAGE_FIELD_W   = 10;
	localparam int unsigned VMAIN_W   = 10;
	localparam int unsigned PORT_CURRENT_FIELD_W   = 13;
	localparam int unsigned STATE_W   = 5;
	localparam int unsigned MEAS_W    = PORT_VOLTAGE_FIELD_W + VMAIN_W + PORT_CURRENT_FIELD_W + STATE_W;

	// Operation select code {hi, lo} that turns on the stream
	localparam logic [1:0] MON_SELECT = 2'h1;
	// Class reported by a load that earns a second class event
	localparam logic [2:0] CLASS_FOUR = 3'h4;

	// Port states; the code is the one sent in the stream
	typedef enum logic [4:0] {
		ST_IDLE    = 5'h00,
		ST_SEARCH  = 5'h03,
		ST_RES_DET = 5'h04,
		ST_BACKOFF = 5'h05,
		ST_CLASS   = 5'h07,
		ST_WAIT_SU = 5'h09,
		ST_CAP_DET = 5'h0B,
		ST_STARTUP = 5'h0D,
		ST_POWERED = 5'h0F,
		ST_UDL     = 5'h11,
		ST_OVLD    = 5'h12,
		ST_VMAIN   = 5'h13
	} ppsm_port_state_t;

	// Stream sender states
	typedef enum logic [1:0] {
		LK_GAP   = 2'h0,
		LK_REQ   = 2'h1,
		LK_SHIFT = 2'h2
	} ppsm_link_state_t;

endpackage

// file: core/ppsm_top.sv
// PoE port sequencer, protection monitor and monitoring stream sender
// Notes on behaviour
// R1: Legacy input low also accepts capacitive loads
// R2: Classify only right after passed resistor detection
// R3: Basic mode uses exactly one class event
// R4: High-power mode: second event only for class 4
// R5: Start-up limits current for 65 ms
// R6: Powered port removes power on over-current/short
// R7: Under 7.5 mA over 322 ms removes power
// R8: Over-temperature removes port power
// R9: Supply above 57.5 V removes port power
// R10: Select code 01 streams registers continuously
// R11: Data on indicator b, clock on indicator a
// R12: One bit per microsecond
// R13: Packet is 116 bits long
// R14: Gap between packets about one microsecond
// R15: Between packets clock low, data steady
// R16: MSB first, fields in fixed order
// R17: Voltage fields count 58 mV per step
// R18: Current field counts 238 uA per step
// R19: State code idle, search, detect, back-off, class
// R20: State code wait, cap, start-up, powered, faults
// R21: Overload or peak limit timeout shuts down
// R22: Retry one second after overload/no-load shutdown
// R23: Test fields carry internal debug content; here they are sent as zeros
// R24: Data changes on falling clock edge
`timescale 1ns/1ns
`default_nettype none

module ppsm_top #(
	parameter int unsigned STARTUP_CYC  = ppsm_pkg::STARTUP_CYC,
	parameter int unsigned UDL_CYC      = ppsm_pkg::UDL_CYC,
	parameter int unsigned OVERLOAD_CYC = ppsm_pkg::OVERLOAD_CYC,
	parameter int unsigned PEAK_LIM_CYC = ppsm_pkg::PEAK_LIM_CYC,
	parameter int unsigned RECOVERY_CYC = ppsm_pkg::RECOVERY_CYC
) (
	input  wire logic        clk_sys_in,              // 20 MHz
	input  wire logic        rst_in,                  // Async, high
	input  wire logic        clk_link_in,             // Stream clock
	input  wire logic        legacy_det_n_in,         // Low: legacy on
	input  wire logic        high_power_in,           // High-power mode
	input  wire logic        operation_select_lo_in,
	input  wire logic        operation_select_hi_in,
	input  wire logic        det_done_in,             // Detection finished
	input  wire logic        det_res_ok_in,           // Resistor found
	input  wire logic        det_cap_ok_in,           // Capacitor found
	input  wire logic        class_done_in,           // Class event done
	input  wire logic [2:0]  class_value_in,          // Class reported
	input  wire logic        over_current_in,         // Above cut level
	input  wire logic        peak_current_limit_in,   // Limiter active
	input  wire logic        under_current_in,        // Below 7.5 mA
	input  wire logic        over_temp_in,            // Above 200 C
	input  wire logic        vmain_high_in,           // Above 57.5 V
	input  wire logic [9:0]  port_voltage_field_adc_in,            // 58 mV per step
	input  wire logic [9:0]  vmain_adc_in,            // 58 mV per step
	input  wire logic [12:0] port_current_field_adc_in,            // 238 uA per step
	output logic             det_res_req_out,
	output logic             det_cap_req_out,
	output logic             class_req_out,
	output logic             class_second_out,
	output logic             port_power_on_out,
	output logic             inrush_limit_out,
	output logic             indicator_out_a,         // Stream clock
	output logic             indicator_out_b          // Stream data
);

	localparam int unsigned TW = ppsm_pkg::TMR_W;

	// =====================================================================
	// Input synchronisers, system domain
	// =====================================================================
	logic [13:0] pin_s1_r;       // First stage, read only by second
	logic [13:0] pin_s2_r;
	logic [32:0] adc_s1_r;
	logic [32:0] adc_s2_r;       // Slow analog values; a torn word lasts
	                             // one cycle and only reaches the stream
	logic        det_d_r;        // Edge detect of detection done
	logic        cls_d_r;        // Edge detect of class done

	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			pin_s1_r <= 14'h0000;
			pin_s2_r <= 14'h0000;
			adc_s1_r <= 33'h000000000;
			adc_s2_r <= 33'h000000000;
			det_d_r  <= 1'b0;
			cls_d_r  <= 1'b0;
		end
		else
		begin
			pin_s1_r <= {legacy_det_n_in, high_power_in, det_done_in,
				det_res_ok_in, det_cap_ok_in, class_done_in,
				class_value_in, over_current_in,
				peak_current_limit_in, under_current_in,
				over_temp_in, vmain_high_in};
			pin_s2_r <= pin_s1_r;
			adc_s1_r <= {port_voltage_field_adc_in, vmain_adc_in, port_current_field_adc_in};
			adc_s2_r <= adc_s1_r;
			det_d_r  <= pin_s2_r[11];
			cls_d_r  <= pin_s2_r[8];
		end
	end

	logic       legacy_n_s;
	logic       at_s;
	logic       res_ok_s;
	logic       cap_ok_s;
	logic [2:0] cls_val_s;
	logic       ovc_s;
	logic       lim_s;
	logic       udc_s;
	logic       temp_s;
	logic       vhi_s;
	logic       det_rise;
	logic       cls_rise;

	assign legacy_n_s = pin_s2_r[13];
	assign at_s       = pin_s2_r[12];
	assign res_ok_s   = pin_s2_r[10];
	assign cap_ok_s   = pin_s2_r[9];
	assign cls_val_s  = pin_s2_r[7:5];
	assign ovc_s      = pin_s2_r[4];
	assign lim_s      = pin_s2_r[3];
	assign udc_s      = pin_s2_r[2];
	assign temp_s     = pin_s2_r[1];
	assign vhi_s      = pin_s2_r[0];
	assign det_rise   = pin_s2_r[11] & ~det_d_r;
	assign cls_rise   = pin_s2_r[8] & ~cls_d_r;

	// =====================================================================
	// Port sequencer
	// =====================================================================
	ppsm_pkg::ppsm_port_state_t state_r;    // Live port state
	ppsm_pkg::ppsm_port_state_t state_nxt;
	logic [TW-1:0] tmr_r;                   // Time in current state
	logic [TW-1:0] ovl_cnt_r;               // Time above cut level
	logic [TW-1:0] lim_cnt_r;               // Time at peak limit
	logic [TW-1:0] udl_cnt_r;               // Time under load
	logic          class_second_r;          // Second class event issued
	logic          need_second;
	logic          powered;

	// Saturating count while enabled, zero otherwise
	function automatic logic [TW-1:0] sat_inc(input logic [TW-1:0] v,
		input logic en);
		if (!en)
			sat_inc = '0;
		else if (v == {TW{1'b1}})
			sat_inc = v;
		else
			sat_inc = v + 1'b1;
	endfunction

	assign need_second = at_s && (cls_val_s == ppsm_pkg::CLASS_FOUR) &&
		!class_second_r;                           // [R3] [R4]
	assign powered = (state_r == ppsm_pkg::ST_POWERED);

	// Next state; supply range beats temperature beats the rest
	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			ppsm_pkg::ST_IDLE:
				state_nxt = ppsm_pkg::ST_SEARCH;
			ppsm_pkg::ST_SEARCH:
				state_nxt = ppsm_pkg::ST_RES_DET;
			ppsm_pkg::ST_RES_DET:
				if (det_rise)
				begin
					if (res_ok_s)
						state_nxt = ppsm_pkg::ST_CLASS;   // [R2]
					else if (!legacy_n_s)
						state_nxt = ppsm_pkg::ST_CAP_DET; // [R1]
					else
						state_nxt = ppsm_pkg::ST_BACKOFF;
				end
			ppsm_pkg::ST_CAP_DET:
				if (det_rise)
					state_nxt = cap_ok_s ? ppsm_pkg::ST_WAIT_SU :
						ppsm_pkg::ST_BACKOFF;             // [R1]
			ppsm_pkg::ST_BACKOFF:
				if (tmr_r >= TW'(ppsm_pkg::BACKOFF_CYC - 1))
					state_nxt = ppsm_pkg::ST_SEARCH;
			ppsm_pkg::ST_CLASS:
				if (cls_rise && !need_second)
					state_nxt = ppsm_pkg::ST_WAIT_SU;     // [R3] [R4]
			ppsm_pkg::ST_WAIT_SU:
				state_nxt = ppsm_pkg::ST_STARTUP;
			ppsm_pkg::ST_STARTUP:
				if (tmr_r >= TW'(STARTUP_CYC - 1))
					state_nxt = ppsm_pkg::ST_POWERED;     // [R5]
			ppsm_pkg::ST_POWERED:
				// Short and overload outrank the slow under-load timer
				if (ovl_cnt_r >= TW'(OVERLOAD_CYC) ||
					lim_cnt_r >= TW'(PEAK_LIM_CYC))
					state_nxt = ppsm_pkg::ST_OVLD;        // [R6] [R21]
				else if (udl_cnt_r >= TW'(UDL_CYC))
					state_nxt = ppsm_pkg::ST_UDL;         // [R7]
			ppsm_pkg::ST_UDL,
			ppsm_pkg::ST_OVLD:
				if (tmr_r >= TW'(RECOVERY_CYC - 1) && !temp_s)
					state_nxt = ppsm_pkg::ST_IDLE;        // [R22]
			ppsm_pkg::ST_VMAIN:
				if (!vhi_s)
					state_nxt = ppsm_pkg::ST_IDLE;
			default:
				state_nxt = ppsm_pkg::ST_IDLE;
		endcase
		// Heat shuts the port and waits out the recovery interval
		if (temp_s && state_r != ppsm_pkg::ST_OVLD &&
			state_r != ppsm_pkg::ST_VMAIN)
			state_nxt = ppsm_pkg::ST_OVLD;                // [R8]
		if (vhi_s)
			state_nxt = ppsm_pkg::ST_VMAIN;               // [R9]
	end

	// State register and state timer
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			state_r <= ppsm_pkg::ST_IDLE;
			tmr_r   <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			tmr_r   <= sat_inc(tmr_r, state_nxt == state_r);
		end
	end

	// Fault qualification timers, only armed while powered
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			ovl_cnt_r <= '0;
			lim_cnt_r <= '0;
			udl_cnt_r <= '0;
		end
		else
		begin
			ovl_cnt_r <= sat_inc(ovl_cnt_r, powered && ovc_s); // [R21]
			lim_cnt_r <= sat_inc(lim_cnt_r, powered && lim_s); // [R21]
			udl_cnt_r <= sat_inc(udl_cnt_r, powered && udc_s); // [R7]
		end
	end

	// Second class event flag, dropped on leaving classification
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			class_second_r <= 1'b0;
		else if (state_r != ppsm_pkg::ST_CLASS)
			class_second_r <= 1'b0;
		else if (cls_rise && need_second)
			class_second_r <= 1'b1;                       // [R4]
	end

	// Front end controls, registered from the state
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			det_res_req_out   <= 1'b0;
			det_cap_req_out   <= 1'b0;
			class_req_out     <= 1'b0;
			class_second_out  <= 1'b0;
			port_power_on_out <= 1'b0;
			inrush_limit_out  <= 1'b0;
		end
		else
		begin
			det_res_req_out   <= (state_r == ppsm_pkg::ST_RES_DET);
			det_cap_req_out   <= (state_r == ppsm_pkg::ST_CAP_DET);
			class_req_out     <= (state_r == ppsm_pkg::ST_CLASS);
			class_second_out  <= class_second_r;
			// Power only in start-up and powered states
			port_power_on_out <= (state_r == ppsm_pkg::ST_STARTUP) ||
				powered;                                  // [R6] [R8] [R9]
			inrush_limit_out  <= (state_r == ppsm_pkg::ST_STARTUP); // [R5]
		end
	end

	chk_class_entry: assert property (@(posedge clk_sys_in)   // [R2]
		disable iff (rst_in)
		(state_r == ppsm_pkg::ST_CLASS &&
		$past(state_r) != ppsm_pkg::ST_CLASS) |->
		($past(state_r) == ppsm_pkg::ST_RES_DET && $past(res_ok_s)))
		else $error("class phase without resistor pass");
	chk_legacy_cap: assert property (@(posedge clk_sys_in)    // [R1]
		disable iff (rst_in)
		(state_r == ppsm_pkg::ST_RES_DET && det_rise && !res_ok_s &&
		!legacy_n_s && !vhi_s && !temp_s) |=>
		state_r == ppsm_pkg::ST_CAP_DET)
		else $error("legacy detection skipped");
	chk_single_event: assert property (@(posedge clk_sys_in)  // [R3]
		disable iff (rst_in)
		(state_r == ppsm_pkg::ST_CLASS && cls_rise && !at_s &&
		!vhi_s && !temp_s) |=> state_r == ppsm_pkg::ST_WAIT_SU)
		else $error("basic mode used more than one class event");
	chk_second_event: assert property (@(posedge clk_sys_in)  // [R4]
		disable iff (rst_in)
		$rose(class_second_r) |->
		$past(at_s && cls_val_s == ppsm_pkg::CLASS_FOUR))
		else $error("second class event without class 4");
	chk_startup_len: assert property (@(posedge clk_sys_in)   // [R5]
		disable iff (rst_in)
		(state_r == ppsm_pkg::ST_POWERED &&
		$past(state_r) == ppsm_pkg::ST_STARTUP) |->
		$past(tmr_r) == TW'(STARTUP_CYC - 1))
		else $error("start-up phase wrong length");
	chk_peak_timeout: assert property (@(posedge clk_sys_in)  // [R21]
		disable iff (rst_in)
		(powered && lim_cnt_r >= TW'(PEAK_LIM_CYC) && !vhi_s) |=>
		state_r == ppsm_pkg::ST_OVLD ##1 !port_power_on_out)
		else $error("peak limit timeout kept power");
	chk_udl_off: assert property (@(posedge clk_sys_in)       // [R7]
		disable iff (rst_in)
		(powered && udl_cnt_r >= TW'(UDL_CYC) && !vhi_s && !temp_s &&
		ovl_cnt_r < TW'(OVERLOAD_CYC) && lim_cnt_r < TW'(PEAK_LIM_CYC))
		|=> state_r == ppsm_pkg::ST_UDL ##1 !port_power_on_out)
		else $error("under-load did not disconnect");
	chk_temp_off: assert property (@(posedge clk_sys_in)      // [R8]
		disable iff (rst_in)
		temp_s |-> ##2 !port_power_on_out)
		else $error("power kept while over temperature");
	chk_vmain_off: assert property (@(posedge clk_sys_in)     // [R9]
		disable iff (rst_in)
		vhi_s |=> state_r == ppsm_pkg::ST_VMAIN ##1 !port_power_on_out)
		else $error("power kept with supply out of range");

	// =====================================================================
	// Snapshot handshake, system side
	// =====================================================================
	logic               sy_req_s1_r;   // First stage of request toggle
	logic               sy_req_s2_r;
	logic               sy_req_seen_r;
	logic               sy_ack_t_r;    // Acknowledge toggle to link side
	logic               lk_req_t_r;    // Request toggle from link side
	logic [ppsm_pkg::MEAS_W-1:0] hold_r; // Stable while link loads it

	// New request: capture fields and toggle acknowledge in the same cycle
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			sy_req_s1_r   <= 1'b0;
			sy_req_s2_r   <= 1'b0;
			sy_req_seen_r <= 1'b0;
			sy_ack_t_r    <= 1'b0;
			hold_r        <= '0;
		end
		else
		begin
			sy_req_s1_r <= lk_req_t_r;
			sy_req_s2_r <= sy_req_s1_r;
			if (sy_req_s2_r != sy_req_seen_r)
			begin
				sy_req_seen_r <= sy_req_s2_r;
				sy_ack_t_r    <= ~sy_ack_t_r;
				// Port V, supply V, port I, live state [R16] [R17] [R18]
				hold_r <= {adc_s2_r, state_r};        // [R19] [R20]
			end
		end
	end

	// =====================================================================
	// Monitoring stream sender, link domain
	// =====================================================================
	localparam int unsigned PB = ppsm_pkg::PKT_BITS;
	localparam int unsigned HC = ppsm_pkg::HALF_CYC;

	ppsm_pkg::ppsm_link_state_t lk_st_r;
	logic [1:0]    lk_mode_s1_r;   // First stage of select pins
	logic [1:0]    lk_mode_s2_r;
	logic          lk_ack_s1_r;    // First stage of acknowledge
	logic          lk_ack_s2_r;
	logic          lk_ack_seen_r;
	logic [PB-1:0] lk_shift_r;     // Packet, MSB leaves first
	logic [6:0]    lk_bit_r;       // Bit index within packet
	logic [2:0]    lk_ph_r;        // Phase within one bit
	logic [2:0]    lk_gap_r;       // Gap length counter

	always_ff @(posedge clk_link_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			lk_mode_s1_r <= 2'h0;
			lk_mode_s2_r <= 2'h0;
			lk_ack_s1_r  <= 1'b0;
			lk_ack_s2_r  <= 1'b0;
		end
		else
		begin
			lk_mode_s1_r <= {operation_select_hi_in, operation_select_lo_in};
			lk_mode_s2_r <= lk_mode_s1_r;
			lk_ack_s1_r  <= sy_ack_t_r;
			lk_ack_s2_r  <= lk_ack_s1_r;
		end
	end

	// Gap, snapshot request, then 116 bits; a packet always finishes
	always_ff @(posedge clk_link_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			lk_st_r         <= ppsm_pkg::LK_GAP;
			lk_ack_seen_r   <= 1'b0;
			lk_req_t_r      <= 1'b0;
			lk_shift_r      <= '0;
			lk_bit_r        <= 7'h00;
			lk_ph_r         <= 3'h0;
			lk_gap_r        <= 3'h0;
			indicator_out_a <= 1'b0;
			indicator_out_b <= 1'b0;
		end
		else
		begin
			unique case (lk_st_r)
				ppsm_pkg::LK_GAP:
				begin
					indicator_out_a <= 1'b0;                 // [R15]
					if (lk_gap_r < 3'(ppsm_pkg::GAP_CYC - 1))
						lk_gap_r <= lk_gap_r + 3'h1;         // [R14]
					else if (lk_mode_s2_r == ppsm_pkg::MON_SELECT)
					begin
						lk_req_t_r <= ~lk_req_t_r;           // [R10]
						lk_st_r    <= ppsm_pkg::LK_REQ;
					end
				end
				ppsm_pkg::LK_REQ:
					if (lk_ack_s2_r != lk_ack_seen_r)
					begin
						lk_ack_seen_r <= lk_ack_s2_r;
						// Test fields carry no debug state here [R23]
						lk_shift_r <= {{ppsm_pkg::TEST_BITS{1'b0}},
							hold_r};                         // [R16]
						lk_bit_r <= 7'h00;
						lk_ph_r  <= 3'h0;
						lk_st_r  <= ppsm_pkg::LK_SHIFT;
					end
				ppsm_pkg::LK_SHIFT:
				begin
					lk_ph_r <= lk_ph_r + 3'h1;
					if (lk_ph_r == 3'h0)
					begin
						// New bit as the clock falls [R24] [R11]
						indicator_out_a <= 1'b0;
						indicator_out_b <= lk_shift_r[PB-1];
						lk_shift_r <= {lk_shift_r[PB-2:0], 1'b0};
					end
					else if (lk_ph_r == 3'(HC))
						indicator_out_a <= 1'b1;             // [R12]
					else if (lk_ph_r == 3'(2 * HC - 1))
					begin
						lk_ph_r <= 3'h0;
						if (lk_bit_r == 7'(PB - 1))
						begin
							lk_gap_r <= 3'h0;                // [R13]
							lk_st_r  <= ppsm_pkg::LK_GAP;
						end
						else
							lk_bit_r <= lk_bit_r + 7'h01;
					end
				end
				default:
					lk_st_r <= ppsm_pkg::LK_GAP;
			endcase
		end
	end

	chk_gap_quiet: assert property (@(posedge clk_link_in)    // [R15]
		disable iff (rst_in)
		(lk_st_r != ppsm_pkg::LK_SHIFT &&
		$past(lk_st_r) != ppsm_pkg::LK_SHIFT) |->
		(!indicator_out_a && $stable(indicator_out_b)))
		else $error("stream lines moved between packets");
	chk_clk_high: assert property (@(posedge clk_link_in)     // [R12]
		disable iff (rst_in)
		$rose(indicator_out_a) |-> indicator_out_a [*3] ##1
		!indicator_out_a [*3])
		else $error("stream clock period wrong");
	chk_data_edge: assert property (@(posedge clk_link_in)    // [R24]
		disable iff (rst_in)
		$changed(indicator_out_b) |-> !indicator_out_a &&
		$past(indicator_out_a) == 1'b1 || !$past(indicator_out_a))
		else $error("data changed while clock high");
	chk_pkt_len: assert property (@(posedge clk_link_in)      // [R13]
		disable iff (rst_in)
		(lk_st_r == ppsm_pkg::LK_GAP &&
		$past(lk_st_r) == ppsm_pkg::LK_SHIFT) |->
		$past(lk_bit_r) == 7'(PB - 1))
		else $error("packet not 116 bits");

endmodule

`default_nettype wire

// file: sim/ppsm_pd_model.sv
// Powered device model answering detection and class requests
`timescale 1ns/1ns
`default_nettype none
module ppsm_pd_model (
	input  wire logic       clk_in,
	input  wire logic       res_req_in,
	input  wire logic       cap_req_in,
	input  wire logic       class_req_in,
	input  wire logic       second_in,
	input  wire logic [2:0] cls_in,
	input  wire logic [4:0] dly_in,
	output logic            det_done_out,
	output logic            class_done_out,
	output logic [2:0]      cls_out
);
	// Class is not held outside an event, so it shows the inverted class there
	assign cls_out = class_req_in ? cls_in : ~cls_in;
	// Detection ends a chosen delay after a request
	always
	begin
		det_done_out = 1'b0;
		// Level wait: the capacitor request rises while done still stands
		wait (res_req_in || cap_req_in);
		repeat (dly_in + 1) @(negedge clk_in);
		det_done_out = 1'b1;
		repeat (4) @(negedge clk_in);
	end
	// One class event, a second only when asked
	always
	begin
		class_done_out = 1'b0;
		@(posedge class_req_in);
		repeat (2)
		begin
			repeat (dly_in + 1) @(negedge clk_in);
			class_done_out = 1'b1;
			repeat (4) @(negedge clk_in);
			class_done_out = 1'b0;
			repeat (8) @(negedge clk_in);
			if (!second_in)
				break;
		end
	end
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// Bench for port sequencing, protection and the monitoring stream
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	localparam int SU = 50, UD = 60, OV = 40, PK = 30;
	logic clk_sys_in = 0, clk_link_in = 0, rst_in = 1, a_q = 0;
	logic legacy_det_n_in = 1, high_power_in = 0, det_res_ok_in = 0;
	logic det_cap_ok_in = 0, operation_select_lo_in = 1;
	logic operation_select_hi_in = 0, det_done_in, class_done_in;
	logic over_current_in = 0, peak_current_limit_in = 0;
	logic under_current_in = 0, over_temp_in = 0, vmain_high_in = 0;
	logic [2:0] cls = 0, class_value_in;
	logic [4:0] dly = 0;
	logic [3:0] q = 0;
	logic [9:0] port_voltage_field_adc_in = 0, vmain_adc_in = 0;
	logic [12:0] port_current_field_adc_in = 0;
	logic det_res_req_out, det_cap_req_out, class_req_out;
	logic class_second_out, port_power_on_out, inrush_limit_out;
	logic indicator_out_a, indicator_out_b;
	logic [115:0] sh = 0, pkt = 0;
	int failures = 0, n_checks = 0, nb = 0, idle = 0, npk = 0, ticks = 0;
	int ncap = 0, ncls = 0, nsec = 0, nin = 0, np0 = 0;
	ppsm_top #(.STARTUP_CYC(SU), .UDL_CYC(UD), .OVERLOAD_CYC(OV),
		.PEAK_LIM_CYC(PK), .RECOVERY_CYC(80)) dut_u (
		.clk_sys_in, .rst_in, .clk_link_in, .legacy_det_n_in,
		.high_power_in, .operation_select_lo_in, .operation_select_hi_in,
		.det_done_in, .det_res_ok_in, .det_cap_ok_in, .class_done_in,
		.class_value_in, .over_current_in, .peak_current_limit_in,
		.under_current_in, .over_temp_in, .vmain_high_in, .port_voltage_field_adc_in,
		.vmain_adc_in, .port_current_field_adc_in, .det_res_req_out, .det_cap_req_out,
		.class_req_out, .class_second_out, .port_power_on_out,
		.inrush_limit_out, .indicator_out_a, .indicator_out_b);
	ppsm_pd_model pd_u (.clk_in(clk_sys_in), .res_req_in(det_res_req_out),
		.cap_req_in(det_cap_req_out), .class_req_in(class_req_out),
		.second_in(class_second_out), .cls_in(cls), .dly_in(dly),
		.det_done_out(det_done_in), .class_done_out(class_done_in),
		.cls_out(class_value_in));
	always #25 clk_sys_in = ~clk_sys_in;
	// Link clock offset so its edges drift against the system clock
	initial
	begin
		#13;
		forever #80 clk_link_in = ~clk_link_in;
	end
	task automatic chk(input logic [37:0] got, exp);
		n_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks=%0d failures=%0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic wait_pwr(input logic v, input int lim, output int n);
		for (n = 0; port_power_on_out !== v && n < lim; n++)
			@(negedge clk_sys_in);
	endtask
	// Two whole packets, so the last one was built after the change
	task automatic wait_pkts();
		int n0;
		n0 = npk;
		for (int i = 0; i < 9000 && npk < n0 + 2; i++)
			@(negedge clk_sys_in);
	endtask
	task automatic run_port(input logic h, r, c, l, input logic [2:0] k);
		int n;
		high_power_in = h;
		det_res_ok_in = r;
		det_cap_ok_in = c;
		legacy_det_n_in = l;
		cls = k;
		dly = 5'($urandom_range(0, 20));
		port_voltage_field_adc_in = 10'($urandom);
		vmain_adc_in = 10'($urandom);
		port_current_field_adc_in = 13'($urandom);
		wait_pwr(1'b1, 9000, n);
		chk({ncls[3:0], ncap[3:0]}, {3'h0, r, 3'h0, !r});
		chk(nsec, h && r && k == 3'h4);
		repeat (SU + 8) @(negedge clk_sys_in);
		chk({port_power_on_out, inrush_limit_out}, 2'h2);
		chk(nin >= SU && nin <= SU + 2, 1'b1);
		wait_pkts();
		chk(pkt[37:0], {port_voltage_field_adc_in, vmain_adc_in, port_current_field_adc_in, 5'h0F});
		$display("port test done at %0t", $time);
	endtask
	task automatic fault(input int k, lo, input logic [4:0] code);
		int n;
		{over_current_in, peak_current_limit_in, under_current_in,
			over_temp_in, vmain_high_in} = 5'(5'h10 >> k);
		wait_pwr(1'b0, lo + 12, n);
		chk(n >= lo && n < lo + 12, 1'b1);
		if (code != 5'h0)
		begin
			wait_pkts();
			chk(pkt[4:0], code);
		end
		{over_current_in, peak_current_limit_in, under_current_in,
			over_temp_in, vmain_high_in} = 5'h0;
		$display("fault test %0d done at %0t", k, $time);
	endtask
	// Receiver takes data on each rising stream clock
	always @(posedge clk_link_in)
	begin
		if (indicator_out_a && !a_q)
		begin
			if (idle > 3 && nb != 0)
				chk({nb == 116, idle >= 7}, 2'h3);
			if (idle > 3)
				nb = 0;
			else
				chk(idle, 3);
			sh = {sh[114:0], indicator_out_b};
			nb++;
			if (nb == 116)
				pkt = sh;
			npk += int'(nb == 116);
		end
		idle = indicator_out_a ? 0 : idle + 1;
		a_q = indicator_out_a;
	end
	// Counts per attempt; a new resistor detection starts them over
	always @(posedge clk_sys_in)
	begin
		if (det_res_req_out && !q[0])
			{ncap, ncls, nsec, nin} = '0;
		ncap += int'(det_cap_req_out && !q[1]);
		ncls += int'(class_req_out && !q[2]);
		nsec += int'(class_second_out && !q[3]);
		nin += int'(inrush_limit_out);
		q = {class_second_out, class_req_out, det_cap_req_out, det_res_req_out};
		ticks++;
		if (ticks == 90000)
		begin
			failures++;
			give_verdict();
		end
	end
	initial
	begin
		void'($urandom(32'h157EAEAD));
		repeat (2) @(negedge clk_sys_in);
		rst_in = 0;
		run_port(0, 1, 0, 1, 3'($urandom_range(0, 4)));
		fault(0, OV, 5'h0);
		run_port(1, 1, 0, 1, 3'h4);
		fault(1, PK, 5'h0);
		run_port(1, 1, 0, 1, 3'($urandom_range(0, 3)));
		fault(2, UD, 5'h0);
		run_port(0, 0, 1, 0, 3'h0);
		fault(3, 0, 5'h12);
		run_port(1, 0, 1, 0, 3'h4);
		fault(4, 0, 5'h13);
		operation_select_hi_in = 1;
		operation_select_lo_in = 0;
		// The packet in flight finishes; then no new packet may start
		repeat (3000) @(negedge clk_sys_in);
		np0 = npk;
		repeat (3000) @(negedge clk_sys_in);
		chk(npk, np0);
		chk({indicator_out_a, indicator_out_b}, {1'b0, pkt[0]});
		give_verdict();
	end
endmodule
`default_nettype wire
